// ==== src/mscg_pkg.sv ====
// constants, types and field layouts for the mark and graphic command parser
// Overview of operation
// - escape, cd, 03, 61 then page span, start gap, mark span; all stored
// - a stop at a mark feeds the full mark span before halting
// - paper still absent after a full mark span feed flags paper out
// - print with no paper feeds one mark span first; still absent stops print
// - form feed in mark mode feeds to next mark or end of page
// - reset values: page 150 mm, start gap 2 mm, mark span 120 eighths
// - escape, cd, 01, 62 then option byte; option resets to zero
// - option bit 0 sends ascii B each time paper goes undetected
// - option bit 1 enables all mark handling
// - lead 1f is followed by exactly 54 raw bytes printed as one line
// - top bit of first byte is leftmost dot, bottom bit of last rightmost
// - lead 202 to 254 starts a compressed line of 256 minus lead bytes
// - compressed zero plus count gives blank bytes; other bytes pass literally
package mscg_pkg;
   localparam logic [7:0] ESC_BYTE = 8'h1b;
   localparam logic [7:0] MARK_GROUP = 8'hcd;
   localparam logic [7:0] PARM_LEN = 8'h03;
   localparam logic [7:0] PARM_SEL = 8'h61;
   localparam logic [7:0] OPT_LEN = 8'h01;
   localparam logic [7:0] OPT_SEL = 8'h62;
   localparam logic [7:0] FF_BYTE = 8'h0c;
   localparam logic [7:0] RAW_LEAD = 8'h1f;
   localparam logic [7:0] NOTE_BYTE = 8'h42;
   localparam int LINE_BYTES = 54;
   localparam int LINE_BITS = LINE_BYTES * 8;
   localparam logic [8:0] LINE_END = 9'h036;
   localparam logic [8:0] LINE_LAST = 9'h035;
   localparam logic [7:0] CMP_LEAD_MIN = 8'hca;
   localparam logic [7:0] CMP_LEAD_MAX = 8'hfe;
   localparam int MM_SHIFT = 3;
   localparam int OPT_NOTE_BIT = 0;
   localparam int OPT_MARK_BIT = 1;
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_CLEAR = 4'h1;
   localparam logic [3:0] REG_ENABLE = 4'h2;
   localparam logic [3:0] REG_MARK = 4'h3;
   localparam logic [3:0] REG_STATE = 4'h4;
   localparam int ST_W = 4;
   localparam int ST_LINE = 0;
   localparam int ST_OUT = 1;
   localparam int ST_MARK = 2;
   localparam int ST_FEED = 3;

   typedef struct packed {
      logic [7:0] page_span;
      logic [7:0] print_start_gap;
      logic [7:0] mark_span;
      logic [7:0] opt;
   } mscg_cfg_t;

   localparam mscg_cfg_t DEF_CFG = '{8'h96, 8'h02, 8'h78, 8'h00};

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } mscg_byte_t;

   typedef enum logic [3:0] {
      P_IDLE = 4'b0000,
      P_E1 = 4'b0001,
      P_E2 = 4'b0010,
      P_E3P = 4'b0011,
      P_E3O = 4'b0100,
      P_PAGE = 4'b0101,
      P_GAP = 4'b0110,
      P_SPAN = 4'b0111,
      P_OPT = 4'b1000,
      P_RAW = 4'b1001,
      P_CMP = 4'b1010,
      P_RUN = 4'b1011
   } mscg_pst_t;

   typedef enum logic [1:0] {
      E_IDLE = 2'b00,
      E_PRE = 2'b01,
      E_SEEK = 2'b10,
      E_MARK = 2'b11
   } mscg_eng_t;
endpackage

// ==== src/mscg_core.sv ====
// byte stream parser, line assembly and mark driven paper feed engine
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module mscg_core (
   input wire logic clk,
   input wire logic sys_rst,
   input wire mscg_pkg::mscg_byte_t rx,
   output logic rx_ready,
   output mscg_pkg::mscg_byte_t tx,
   input wire logic paper_present,
   input wire logic step_tick,
   output logic feed_on,
   output logic [mscg_pkg::LINE_BITS-1:0] dot_line,
   output logic dot_line_valid,
   output logic paper_out,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [31:0] reg_rdata,
   output logic irq
);
   mscg_pkg::mscg_pst_t pst;
   mscg_pkg::mscg_eng_t eng, next_eng;
   mscg_pkg::mscg_cfg_t cfg;
   logic [0:mscg_pkg::LINE_BYTES-1][7:0] line_buf;
   logic [8:0] idx;
   logic [7:0] cnt;
   logic [10:0] steps;
   logic line_done, paper_prev;
   logic [mscg_pkg::ST_W-1:0] status, enable, next_status;
   logic ev_line, ev_out, ev_mark, ev_feed;

   wire take = rx.valid & rx_ready;
   wire mark_mode = cfg.opt[mscg_pkg::OPT_MARK_BIT];
   wire is_cmp = rx.data >= mscg_pkg::CMP_LEAD_MIN &&
      rx.data <= mscg_pkg::CMP_LEAD_MAX;
   wire in_line = idx < mscg_pkg::LINE_END;
   wire [5:0] slot = idx[5:0];
   wire [8:0] run_sum = idx + {1'b0, rx.data};
   wire [8:0] run_next = (run_sum > mscg_pkg::LINE_END) ?
      mscg_pkg::LINE_END : run_sum;
   wire raw_end = pst == mscg_pkg::P_RAW && idx == mscg_pkg::LINE_LAST;
   wire cmp_end = (pst == mscg_pkg::P_CMP || pst == mscg_pkg::P_RUN) &&
      cnt == 8'h01;
   wire line_end = take & (raw_end | cmp_end);
   wire ff_cmd = take && pst == mscg_pkg::P_IDLE &&
      rx.data == mscg_pkg::FF_BYTE && mark_mode;
   wire go_pre = line_done & mark_mode & ~paper_present;
   wire [10:0] span_steps = {3'h0, cfg.mark_span};
   wire [10:0] page_steps = {3'h0, cfg.page_span} << mscg_pkg::MM_SHIFT;
   wire [10:0] steps_inc = steps + 11'h001;
   wire span_done = step_tick && steps_inc >= span_steps;
   wire page_done = step_tick && steps_inc >= page_steps;
   wire paper_fall = paper_prev & ~paper_present;
   wire [mscg_pkg::ST_W-1:0] clr_mask = (reg_we &&
      reg_addr == mscg_pkg::REG_CLEAR) ? reg_wdata[mscg_pkg::ST_W-1:0] : '0;
   wire [mscg_pkg::ST_W-1:0] events;
   assign events[mscg_pkg::ST_LINE] = ev_line;
   assign events[mscg_pkg::ST_OUT] = ev_out;
   assign events[mscg_pkg::ST_MARK] = ev_mark;
   assign events[mscg_pkg::ST_FEED] = ev_feed;
   wire [31:0] rd_mux =
      (reg_addr == mscg_pkg::REG_STATUS) ? {28'h0, status} :
      (reg_addr == mscg_pkg::REG_ENABLE) ? {28'h0, enable} :
      (reg_addr == mscg_pkg::REG_MARK) ? cfg :
      (reg_addr == mscg_pkg::REG_STATE) ?
         {25'h0, paper_out, eng, pst} : 32'h0;

   // parser: command recognition and line assembly
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pst <= mscg_pkg::P_IDLE;
         cfg <= mscg_pkg::DEF_CFG;
         idx <= '0;
         cnt <= '0;
         line_buf <= '0;
         line_done <= 1'b0;
      end else begin
         line_done <= line_end;
         if (take) begin
            case (pst)
               mscg_pkg::P_IDLE: begin
                  idx <= '0;
                  if (rx.data == mscg_pkg::ESC_BYTE) begin
                     pst <= mscg_pkg::P_E1;
                  end else if (rx.data == mscg_pkg::RAW_LEAD) begin
                     pst <= mscg_pkg::P_RAW;
                     line_buf <= '0;
                  end else if (is_cmp) begin
                     pst <= mscg_pkg::P_CMP;
                     cnt <= 8'h00 - rx.data;
                     line_buf <= '0;
                  end
               end
               mscg_pkg::P_E1: begin
                  pst <= (rx.data == mscg_pkg::MARK_GROUP) ?
                     mscg_pkg::P_E2 : mscg_pkg::P_IDLE;
               end
               mscg_pkg::P_E2: begin
                  if (rx.data == mscg_pkg::PARM_LEN) begin
                     pst <= mscg_pkg::P_E3P;
                  end else if (rx.data == mscg_pkg::OPT_LEN) begin
                     pst <= mscg_pkg::P_E3O;
                  end else begin
                     pst <= mscg_pkg::P_IDLE;
                  end
               end
               mscg_pkg::P_E3P: begin
                  pst <= (rx.data == mscg_pkg::PARM_SEL) ?
                     mscg_pkg::P_PAGE : mscg_pkg::P_IDLE;
               end
               mscg_pkg::P_E3O: begin
                  pst <= (rx.data == mscg_pkg::OPT_SEL) ?
                     mscg_pkg::P_OPT : mscg_pkg::P_IDLE;
               end
               mscg_pkg::P_PAGE: begin
                  cfg.page_span <= rx.data;
                  pst <= mscg_pkg::P_GAP;
               end
               mscg_pkg::P_GAP: begin
                  cfg.print_start_gap <= rx.data;
                  pst <= mscg_pkg::P_SPAN;
               end
               mscg_pkg::P_SPAN: begin
                  cfg.mark_span <= rx.data;
                  pst <= mscg_pkg::P_IDLE;
               end
               mscg_pkg::P_OPT: begin
                  cfg.opt <= rx.data;
                  pst <= mscg_pkg::P_IDLE;
               end
               mscg_pkg::P_RAW: begin
                  line_buf[slot] <= rx.data;
                  idx <= idx + 9'h001;
                  if (raw_end) begin
                     pst <= mscg_pkg::P_IDLE;
                  end
               end
               mscg_pkg::P_CMP: begin
                  cnt <= cnt - 8'h01;
                  if (rx.data != 8'h00) begin
                     if (in_line) begin
                        line_buf[slot] <= rx.data;
                        idx <= idx + 9'h001;
                     end
                  end
                  if (cmp_end) begin
                     pst <= mscg_pkg::P_IDLE;
                  end else if (rx.data == 8'h00) begin
                     pst <= mscg_pkg::P_RUN;
                  end
               end
               mscg_pkg::P_RUN: begin
                  cnt <= cnt - 8'h01;
                  idx <= run_next;
                  pst <= cmp_end ? mscg_pkg::P_IDLE : mscg_pkg::P_CMP;
               end
               default: pst <= mscg_pkg::P_IDLE;
            endcase
         end
      end
   end

   // feed engine next state and events
   always_comb begin
      next_eng = eng;
      ev_line = 1'b0;
      ev_out = 1'b0;
      ev_mark = 1'b0;
      ev_feed = 1'b0;
      case (eng)
         mscg_pkg::E_IDLE: begin
            if (go_pre) begin
               next_eng = mscg_pkg::E_PRE;
            end else if (line_done) begin
               ev_line = 1'b1;
            end else if (ff_cmd) begin
               next_eng = mscg_pkg::E_SEEK;
            end
         end
         mscg_pkg::E_PRE: begin
            if (span_done) begin
               next_eng = mscg_pkg::E_IDLE;
               ev_feed = 1'b1;
               ev_line = paper_present;
               ev_out = ~paper_present;
            end
         end
         mscg_pkg::E_SEEK: begin
            if (step_tick && !paper_present) begin
               next_eng = mscg_pkg::E_MARK;
               ev_mark = 1'b1;
            end else if (page_done) begin
               next_eng = mscg_pkg::E_IDLE;
               ev_feed = 1'b1;
            end
         end
         mscg_pkg::E_MARK: begin
            if (span_done) begin
               next_eng = mscg_pkg::E_IDLE;
               ev_feed = 1'b1;
               ev_out = ~paper_present;
            end
         end
         default: next_eng = mscg_pkg::E_IDLE;
      endcase
   end

   assign next_status = (status & ~clr_mask) | events;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         eng <= mscg_pkg::E_IDLE;
         steps <= '0;
         feed_on <= 1'b0;
         rx_ready <= 1'b0;
         dot_line <= '0;
         dot_line_valid <= 1'b0;
         paper_out <= 1'b0;
      end else begin
         eng <= next_eng;
         steps <= (next_eng != eng) ? 11'h000 :
            (step_tick ? steps_inc : steps);
         feed_on <= next_eng != mscg_pkg::E_IDLE;
         rx_ready <= next_eng == mscg_pkg::E_IDLE && !line_end &&
            !ff_cmd && !go_pre;
         dot_line_valid <= ev_line;
         if (ev_line) begin
            dot_line <= line_buf;
         end
         paper_out <= ev_out | (paper_out & ~paper_present);
      end
   end

   // host notification, status, interrupt and register reads
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         paper_prev <= 1'b1;
         tx <= '0;
         status <= '0;
         enable <= '0;
         irq <= 1'b0;
         reg_rdata <= '0;
      end else begin
         paper_prev <= paper_present;
         tx.valid <= paper_fall & cfg.opt[mscg_pkg::OPT_NOTE_BIT];
         tx.data <= mscg_pkg::NOTE_BYTE;
         status <= next_status;
         if (reg_we && reg_addr == mscg_pkg::REG_ENABLE) begin
            enable <= reg_wdata[mscg_pkg::ST_W-1:0];
         end
         irq <= |(next_status & enable);
         reg_rdata <= reg_re ? rd_mux : 32'h0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_param_span_store: assert property (
      take && pst == mscg_pkg::P_SPAN |=> cfg.mark_span == $past(rx.data))
      else $error("mark span not stored");
   a_option_store: assert property (
      take && pst == mscg_pkg::P_OPT |=> cfg.opt == $past(rx.data))
      else $error("option byte not stored");
   a_reset_defaults: assert property (
      $past(sys_rst) |-> cfg == mscg_pkg::DEF_CFG)
      else $error("defaults wrong after reset");
   a_mark_feed_end: assert property (
      eng == mscg_pkg::E_MARK && span_done |=> eng == mscg_pkg::E_IDLE
      ##0 !feed_on)
      else $error("mark feed did not stop at mark span");
   a_paper_out_flag: assert property (
      eng == mscg_pkg::E_MARK && span_done && !paper_present |=> paper_out)
      else $error("paper out not flagged");
   a_pre_feed_hold: assert property (
      go_pre |=> eng == mscg_pkg::E_PRE && !dot_line_valid && feed_on)
      else $error("no paper print did not pre feed");
   a_form_feed: assert property (
      ff_cmd |=> eng == mscg_pkg::E_SEEK ##1 feed_on)
      else $error("form feed not started");
   a_mark_gate: assert property (
      eng != mscg_pkg::E_IDLE |-> mark_mode)
      else $error("feed engine active without mark mode");
   a_note_send: assert property (
      paper_fall && cfg.opt[mscg_pkg::OPT_NOTE_BIT] |=>
      tx.valid && tx.data == mscg_pkg::NOTE_BYTE)
      else $error("notification byte missing");
   a_raw_end: assert property (
      take && raw_end |=> pst == mscg_pkg::P_IDLE && line_done)
      else $error("raw line did not end at 54 bytes");
   a_cmp_count: assert property (
      take && pst == mscg_pkg::P_IDLE && is_cmp |=>
      pst == mscg_pkg::P_CMP && cnt == 8'h00 - $past(rx.data))
      else $error("compressed count wrong");
   a_literal_pass: assert property (
      take && pst == mscg_pkg::P_CMP && rx.data != 8'h00 && in_line |=>
      line_buf[$past(slot)] == $past(rx.data))
      else $error("literal byte lost");

   c_raw_line: cover property (take && raw_end ##2 dot_line_valid);
   c_zero_run: cover property (take && pst == mscg_pkg::P_RUN);
   c_ff_mark: cover property (eng == mscg_pkg::E_SEEK ##1
      eng == mscg_pkg::E_MARK);
   c_paper_out: cover property ($rose(paper_out));
endmodule // mscg_core

// ==== testbench/mscg_host.sv ====
// host model that offers command bytes on the byte port
`timescale 1ns/100ps
module mscg_host (
   input wire logic clk,
   input wire logic rx_ready,
   output mscg_pkg::mscg_byte_t rx
);
   initial rx = '0;
   // callers keep mark parameters nonzero
   // callers keep the start gap inside the page
   // callers send a line raw when packing would grow it
   // offer one byte, hold it until taken, then idle for gap cycles
   task automatic send(input logic [7:0] b, input int gap);
      rx <= '{1'b1, b};
      @(posedge clk);
      while (rx_ready !== 1'b1) @(posedge clk);
      if (gap > 0) begin
         rx <= '{1'b0, ~b};
         repeat (gap) @(posedge clk);
      end
   endtask
endmodule // mscg_host

// ==== testbench/mark_sense_graphic_cmd_tb.sv ====
// self-checking bench for the mark and graphic command parser
`timescale 1ns/100ps
module mark_sense_graphic_cmd_tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic rx_ready, feed_on, dot_line_valid, paper_out, irq;
   mscg_pkg::mscg_byte_t rx, tx;
   logic paper_present = 1'b1;
   logic step_tick = 1'b0;
   logic [mscg_pkg::LINE_BITS-1:0] dot_line, last_line, exp;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata, rd;
   logic reg_we = 1'b0;
   logic reg_re = 1'b0;
   logic [7:0] last_b;
   logic [7:0] q[$];
   int n_errors = 0;
   int checked = 0;
   int lines = 0, n_b = 0, ticks = 0, cyc = 0;

   always #25 clk = ~clk;

   mscg_core uut (.clk(clk), .sys_rst(sys_rst), .rx(rx),
      .rx_ready(rx_ready), .tx(tx), .paper_present(paper_present),
      .step_tick(step_tick), .feed_on(feed_on), .dot_line(dot_line),
      .dot_line_valid(dot_line_valid), .paper_out(paper_out),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
      .reg_re(reg_re), .reg_rdata(reg_rdata), .irq(irq));
   mscg_host hm (.clk(clk), .rx_ready(rx_ready), .rx(rx));

   always @(posedge clk) begin
      cyc <= cyc + 1;
      step_tick <= (cyc % 4 == 3);
      if (dot_line_valid === 1'b1) begin
         lines <= lines + 1;
         last_line <= dot_line;
      end
      if (tx.valid === 1'b1) begin
         n_b <= n_b + 1;
         last_b <= tx.data;
      end
      if (feed_on === 1'b1 && step_tick === 1'b1) ticks <= ticks + 1;
      if (cyc == 20000) begin
         n_errors++;
         stop_test();
      end
   end

   task automatic chk(input string w, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask

   task automatic chk_line(input logic [431:0] e);
      checked++;
      if (last_line !== e) begin
         n_errors++;
         $display("ERROR dot_line expected %h seen %h", e, last_line);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge clk);
      reg_we <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rdr(input logic [3:0] a);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge clk);
      reg_re <= 1'b0;
      @(posedge clk);
      rd = reg_rdata;
   endtask

   task automatic put(input logic [7:0] b[$]);
      foreach (b[i]) hm.send(b[i], (i == b.size() - 1) ? 1 : 0);
   endtask

   task automatic send_line(input logic [7:0] b[$]);
      int n0 = lines;
      put(b);
      for (int i = 0; i < 100 && lines == n0; i++) @(posedge clk);
      chk("line count", n0 + 1, lines);
   endtask

   task automatic t_reset();
      rdr(mscg_pkg::REG_MARK);
      chk("mark cfg", 32'h96027800, rd);
      rdr(4'hf);
      chk("unmapped", 32'h0, rd);
      $display("test reset done");
   endtask

   task automatic t_params();
      put({8'h1b, 8'hcd, 8'h03, 8'h61, 8'h64, 8'h03, 8'h10});
      rdr(mscg_pkg::REG_MARK);
      chk("mark cfg", 32'h64031000, rd);
      put({8'h0c, 8'h1b, 8'h00});
      rdr(mscg_pkg::REG_STATE);
      chk("idle state", 32'h0, rd);
      $display("test params done");
   endtask

   task automatic t_raw();
      logic [7:0] b;
      wr(mscg_pkg::REG_ENABLE, 32'h1);
      q = {8'h1f};
      for (int i = 0; i < 54; i++) begin
         b = (i == 0) ? 8'h80 : (i == 53) ? 8'h01 : 8'(i);
         q.push_back(b);
         exp[431 - 8 * i -: 8] = b;
      end
      send_line(q);
      chk_line(exp);
      chk("irq", 32'h1, {31'h0, irq});
      wr(mscg_pkg::REG_CLEAR, 32'h1);
      rdr(mscg_pkg::REG_STATUS);
      chk("status", 32'h0, rd & 32'h1);
      chk("irq", 32'h0, {31'h0, irq});
      wr(mscg_pkg::REG_ENABLE, 32'h0);
      $display("test raw done");
   endtask

   task automatic t_cmp();
      q = {8'hca};
      for (int i = 0; i < 54; i++) q.push_back(8'h5a);
      send_line(q);
      chk_line({54{8'h5a}});
      send_line({8'hfc, 8'h81, 8'h00, 8'h05, 8'h7e});
      exp = '0;
      exp[431 -: 8] = 8'h81;
      exp[383 -: 8] = 8'h7e;
      chk_line(exp);
      send_line({8'hfe, 8'h00, 8'hff});
      chk_line('0);
      chk("masked irq", 32'h0, {31'h0, irq});
      $display("test compressed done");
   endtask

   task automatic t_note();
      int n0 = n_b;
      put({8'h1b, 8'hcd, 8'h01, 8'h62, 8'h01});
      rdr(mscg_pkg::REG_MARK);
      chk("option", 32'h01, rd & 32'hff);
      repeat (2) begin
         paper_present <= 1'b0;
         repeat (4) @(posedge clk);
         paper_present <= 1'b1;
         repeat (4) @(posedge clk);
      end
      chk("note count", n0 + 2, n_b);
      chk("note byte", 32'h42, {24'h0, last_b});
      $display("test note done");
   endtask

   task automatic t_mark();
      int n0;
      put({8'h1b, 8'hcd, 8'h01, 8'h62, 8'h03});
      n0 = lines;
      ticks = 0;
      paper_present <= 1'b0;
      q = {8'h1f};
      repeat (54) q.push_back(8'h00);
      put(q);
      for (int i = 0; i < 600 && paper_out !== 1'b1; i++) @(posedge clk);
      chk("paper out", 32'h1, {31'h0, paper_out});
      chk("feed ticks", 32'h10, ticks);
      chk("no line", n0, lines);
      paper_present <= 1'b1;
      repeat (3) @(posedge clk);
      chk("paper back", 32'h0, {31'h0, paper_out});
      ticks = 0;
      put({8'h0c});
      repeat (40) @(posedge clk);
      paper_present <= 1'b0;
      repeat (8) @(posedge clk);
      paper_present <= 1'b1;
      for (int i = 0; i < 1000 && feed_on !== 1'b0; i++) @(posedge clk);
      chk("ff to mark", 32'h1, ticks > 16 && ticks < 40);
      chk("short gap", 32'h0, {31'h0, paper_out});
      rdr(mscg_pkg::REG_STATUS);
      chk("status", 32'hf, rd);
      $display("test mark done");
   endtask

   task automatic t_rst();
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rdr(mscg_pkg::REG_MARK);
      chk("mark cfg", 32'h96027800, rd);
      rdr(mscg_pkg::REG_STATUS);
      chk("status", 32'h0, rd);
      $display("test reset again done");
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_params();
      t_raw();
      t_cmp();
      t_note();
      t_mark();
      t_rst();
      stop_test();
   end
endmodule // mark_sense_graphic_cmd_tb
